// *** src/pwmc_defines.svh ***
// constants for the four-generator pwm period, phase and duty core
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses
`ifndef PWMC_DEFINES_SVH
`define PWMC_DEFINES_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define PWMC_NGEN 4
`define PWMC_CW 13
`define PWMC_RW 16
`define PWMC_FINE_W 3
`define PWMC_ADR_W 8

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define PWMC_MOD_CTRL_OFS 8'h00
`define PWMC_PRIMARY_PERIOD_OFS 8'h04
`define PWMC_SHARED_DUTY_OFS 8'h08
`define PWMC_STATUS_OFS 8'h0c
`define PWMC_GEN_CTRL_OFS 4'h0
`define PWMC_PHASE_OFS 4'h4
`define PWMC_GEN_DUTY_OFS 4'h8

// ----------------------------------------
// fields
// ----------------------------------------
`define PWMC_MODULE_ENABLE_BIT 0
`define PWMC_IUE_BIT 0
`define PWMC_INDEP_TB_BIT 1
`define PWMC_INDEP_OUT_BIT 2
`define PWMC_USE_SHARED_BIT 3

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define PWMC_PERIOD_RST 16'hfff8
`define PWMC_REG_RST 16'h0000
`define PWMC_DUTY_MIN 16'h0008
`define PWMC_DUTY_MAX 16'hffef

// ----------------------------------------
// time-base figures at the 30 mips point
// ----------------------------------------
`define PWMC_TB_MHZ 120
`define PWMC_PERIOD_RES_PS 8400
`define PWMC_DUTY_RES_PS 1050

`endif

// *** src/pwmc_pkg.sv ***
// types shared by the pwm period, phase and duty core
// assumes pwmc_defines.svh is included by the design files
package pwmc_pkg;

  // per-generator control bits
  typedef struct packed {
    logic use_shared;
    logic indep_out;
    logic indep_tb;
    logic immediate_update_enable;
  } pwmc_genctl_t;

  // one output pin pair
  typedef struct packed {
    logic hi;
    logic lo;
  } pwmc_pair_t;

endpackage

// *** src/pwmc_core.sv ***
// pwm core: primary time base, four individual time bases, duty compare,
// pin-pair formatting and a classic wishbone register slave.
// assumes a single 100 mhz clock; pins feed external gate drivers.
//
// What this block does
// - primary time base counts to the 13-bit primary_period field.
// - primary_period may be written at any time while running.
// - independent time base takes its period from phase_offset.
// - time base nominally ticks at 120 mhz giving 8.4 ns period step.
// - one duty lsb moves the edge by 1.05 ns at 30 mips.
// - finest duty step comes from a fixed-delay element outside.
// - period compare uses only primary_period bits 15 down to 3.
// - individual_counter loads from phase_offset to set output shift.
// - phase writes go to a shadow, moved on individual time base reset.
// - in lock-step mode, transferred phase reaches the output only at master reset.
// - in lock-step mode, phase above the period saturates to the period.
// - four generators each with own 16-bit duty, plus shared duty.
// - generators may take duty from the shared duty register.
// - time base counters are 13 bits and advance every tick.
// - output active while counter is at or below duty bits 15:3.
// - low three duty bits go out to fine edge-adjust logic.
// - new duty waits for primary rollover unless immediate update set.
// - complementary mode drives pwm on high pin, inverse on low pin.
// - complementary format is the default except independent output.
// - independent output mode drives same pwm on both pins.
// - duty below 0x0008 produces no output pulse.
// - primary match clears primary counter, reloads lock-step individual counters.
// - independent counter counts to its phase value then restarts.
// - clearing module enable clears all time base counters.
`timescale 1ns/1ps
`default_nettype none
`include "pwmc_defines.svh"

module pwmc_core (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [`PWMC_ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // output pairs
  output logic [`PWMC_NGEN-1:0] pwm_high_out,
  output logic [`PWMC_NGEN-1:0] pwm_low_out,
  // fine edge-adjust codes, three bits per generator
  output logic [`PWMC_NGEN*`PWMC_FINE_W-1:0] fine_adjust
);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic ack_q;
  logic [31:0] dat_q;
  wire req = cyc_i & stb_i;
  wire wr_take = req & we_i & ack_q;
  wire [3:0] gen_slot = adr_i[7:4];
  wire [3:0] gen_reg = adr_i[3:0];
  wire is_gen = (gen_slot != 4'h0) && (gen_slot <= 4'h4);
  wire [1:0] gen_idx = 2'(gen_slot - 4'h1);
  wire wr_mod_ctrl = wr_take && (adr_i == `PWMC_MOD_CTRL_OFS);
  wire wr_period = wr_take && (adr_i == `PWMC_PRIMARY_PERIOD_OFS);
  wire wr_shared = wr_take && (adr_i == `PWMC_SHARED_DUTY_OFS);

  // byte lanes onto a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // ----------------------------------------
  // module registers
  // ----------------------------------------
  logic module_enable_bit_q;
  logic [15:0] primary_period_q;
  logic [15:0] shared_duty_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      module_enable_bit_q <= 1'b0;
    end else if (wr_mod_ctrl && sel_i[0]) begin
      module_enable_bit_q <= dat_i[`PWMC_MODULE_ENABLE_BIT];
    end
  end

  // period is taken live: no need to stop the module first
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      primary_period_q <= `PWMC_PERIOD_RST;
    end else if (wr_period) begin
      primary_period_q <= lane_merge(primary_period_q, dat_i, sel_i);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shared_duty_q <= `PWMC_REG_RST;
    end else if (wr_shared) begin
      shared_duty_q <= lane_merge(shared_duty_q, dat_i, sel_i);
    end
  end

  // ----------------------------------------
  // primary time base
  // ----------------------------------------
  // one tick per clk_sys edge; the 120 mhz figure scales only the step size
  logic [`PWMC_CW-1:0] primary_counter_q;
  wire en = module_enable_bit_q;
  wire [`PWMC_CW-1:0] period_field = primary_period_q[15:3];
  wire primary_match = en && (primary_counter_q == period_field);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      primary_counter_q <= '0;
    end else if (!en) begin
      primary_counter_q <= '0;
    end else if (primary_match) begin
      primary_counter_q <= '0;
    end else begin
      primary_counter_q <= primary_counter_q + 1'b1;
    end
  end

  // ----------------------------------------
  // per-generator logic
  // ----------------------------------------
  pwmc_pkg::pwmc_genctl_t [`PWMC_NGEN-1:0] genctl_q;
  logic [`PWMC_NGEN-1:0][15:0] phase_offset_q;
  logic [`PWMC_NGEN-1:0][15:0] generator_duty_q;
  logic [`PWMC_NGEN-1:0][`PWMC_CW-1:0] phase_act_q;
  logic [`PWMC_NGEN-1:0][`PWMC_CW-1:0] individual_counter_q;
  logic [`PWMC_NGEN-1:0][15:0] duty_act_q;
  pwmc_pkg::pwmc_pair_t [`PWMC_NGEN-1:0] pair_q;
  logic [`PWMC_NGEN-1:0] pwm_q;

  genvar g;
  generate
    for (g = 0; g < `PWMC_NGEN; g++) begin : gen_pwm
      wire sel_me = wr_take && is_gen && (gen_idx == 2'(g));
      wire wr_ctl = sel_me && (gen_reg == `PWMC_GEN_CTRL_OFS);
      wire wr_ph = sel_me && (gen_reg == `PWMC_PHASE_OFS);
      wire wr_dc = sel_me && (gen_reg == `PWMC_GEN_DUTY_OFS);
      wire indep_tb = genctl_q[g].indep_tb;
      wire [`PWMC_CW-1:0] ic = individual_counter_q[g];
      wire [`PWMC_CW-1:0] ph_raw = phase_offset_q[g][15:3];
      // saturate against the period; own period in independent mode
      wire [`PWMC_CW-1:0] ph_sat = (ph_raw > period_field) ? period_field : ph_raw;
      wire [`PWMC_CW-1:0] ph_next = indep_tb ? ph_raw : ph_sat;
      wire [`PWMC_CW-1:0] own_per = indep_tb ? phase_act_q[g] : period_field;
      wire own_wrap = en && (ic == own_per);
      wire itb_reset = indep_tb ? own_wrap : (own_wrap || primary_match);
      wire [15:0] duty_sel = genctl_q[g].use_shared ? shared_duty_q
                                                    : generator_duty_q[g];
      wire duty_load = primary_match || genctl_q[g].immediate_update_enable;
      wire duty_ok = duty_act_q[g] >= `PWMC_DUTY_MIN;
      wire pwm_d = en && duty_ok && (ic <= duty_act_q[g][15:3]);

      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          genctl_q[g] <= '0;
        end else if (wr_ctl && sel_i[0]) begin
          genctl_q[g] <= pwmc_pkg::pwmc_genctl_t'(dat_i[3:0]);
        end
      end

      // software writes land in the shadow copy only
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          phase_offset_q[g] <= `PWMC_REG_RST;
        end else if (wr_ph) begin
          phase_offset_q[g] <= lane_merge(phase_offset_q[g], dat_i, sel_i);
        end
      end

      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          generator_duty_q[g] <= `PWMC_REG_RST;
        end else if (wr_dc) begin
          generator_duty_q[g] <= lane_merge(generator_duty_q[g], dat_i, sel_i);
        end
      end

      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          phase_act_q[g] <= '0;
        end else if (itb_reset) begin
          phase_act_q[g] <= ph_next;
        end
      end

      // lock-step counters reload their phase at the master reset
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          individual_counter_q[g] <= '0;
        end else if (!en) begin
          individual_counter_q[g] <= '0;
        end else if (!indep_tb && primary_match) begin
          individual_counter_q[g] <= phase_act_q[g];
        end else if (own_wrap) begin
          individual_counter_q[g] <= '0;
        end else begin
          individual_counter_q[g] <= ic + 1'b1;
        end
      end

      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          duty_act_q[g] <= '0;
        end else if (duty_load) begin
          duty_act_q[g] <= duty_sel;
        end
      end

      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          pwm_q[g] <= 1'b0;
        end else begin
          pwm_q[g] <= pwm_d;
        end
      end

      // pins go quiet while disabled so neither switch is left on
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          pair_q[g] <= '0;
        end else if (!en) begin
          pair_q[g] <= '0;
        end else if (genctl_q[g].indep_out) begin
          pair_q[g] <= '{hi: pwm_d, lo: pwm_d};
        end else begin
          pair_q[g] <= '{hi: pwm_d, lo: ~pwm_d};
        end
      end

      assign pwm_high_out[g] = pair_q[g].hi;
      assign pwm_low_out[g] = pair_q[g].lo;
      // the sub-step edge delay itself lives in the pad-side delay line
      assign fine_adjust[g*`PWMC_FINE_W +: `PWMC_FINE_W] = duty_act_q[g][2:0];
    end
  endgenerate

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire [31:0] status_word = {20'h00000, pwm_q, 7'h00, en};
  wire [31:0] gen_word =
    (gen_reg == `PWMC_GEN_CTRL_OFS) ? {28'h0000000, 4'(genctl_q[gen_idx])} :
    (gen_reg == `PWMC_PHASE_OFS) ? {16'h0000, phase_offset_q[gen_idx]} :
    (gen_reg == `PWMC_GEN_DUTY_OFS) ? {16'h0000, generator_duty_q[gen_idx]} :
    32'h00000000;
  wire [31:0] rd_word =
    (adr_i == `PWMC_MOD_CTRL_OFS) ? {31'h00000000, en} :
    (adr_i == `PWMC_PRIMARY_PERIOD_OFS) ? {16'h0000, primary_period_q} :
    (adr_i == `PWMC_SHARED_DUTY_OFS) ? {16'h0000, shared_duty_q} :
    (adr_i == `PWMC_STATUS_OFS) ? status_word :
    is_gen ? gen_word : 32'h00000000;

  // ----------------------------------------
  // handshake
  // ----------------------------------------
  // one wait state: ack follows the request by one edge, then drops
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dat_q <= 32'h00000000;
    end else if (req & ~ack_q) begin
      dat_q <= rd_word;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

endmodule

`default_nettype wire

// *** bench/pwmc_core_props.sv ***
// checker: port-level assertions for pwmc_core, pair 0 shadowed from bus writes
// assumes it is bound to pwmc_core and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module pwmc_core_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // pins
  input wire logic [3:0] pwm_high_out,
  input wire logic [3:0] pwm_low_out,
  input wire logic [11:0] fine_adjust
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // --------------------------------
  // shadows
  // --------------------------------
  logic en_q;
  logic [3:0] ctl_q;
  logic [15:0] per_q, ph_q, dut_q;
  logic [13:0] hi_q, gap_q;
  logic [2:0] rc_q;
  logic [1:0] qt_q;
  wire wr = cyc_i && stb_i && we_i && ack_o;
  wire [15:0] msk = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  wire [15:0] nv = dat_i[15:0] & msk;
  wire h0 = pwm_high_out[0];
  // rise counting skips the periods in which a pending phase or duty may land
  wire run = en_q && ctl_q[3:1] == 3'h0 && dut_q >= 16'h0008 &&
    dut_q[15:3] < per_q[15:3] && rc_q >= 3'h4;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      en_q <= 1'b0;
      ctl_q <= 4'h0;
      per_q <= 16'hfff8;
      ph_q <= 16'h0;
      dut_q <= 16'h0;
      hi_q <= 14'h0;
      gap_q <= 14'h0;
      rc_q <= 3'h0;
      qt_q <= 2'h0;
    end else begin
      en_q <= (wr && adr_i == 8'h00 && sel_i[0]) ? dat_i[0] : en_q;
      ctl_q <= (wr && adr_i == 8'h10 && sel_i[0]) ? dat_i[3:0] : ctl_q;
      per_q <= (wr && adr_i == 8'h04) ? (per_q & ~msk) | nv : per_q;
      ph_q <= (wr && adr_i == 8'h14) ? (ph_q & ~msk) | nv : ph_q;
      dut_q <= (wr && adr_i == 8'h18) ? (dut_q & ~msk) | nv : dut_q;
      hi_q <= h0 ? hi_q + 14'h1 : 14'h0;
      gap_q <= $rose(h0) ? 14'h1 : gap_q + 14'h1;
      rc_q <= wr ? 3'h0 : ($rose(h0) && rc_q != 3'h7) ? rc_q + 3'h1 : rc_q;
      qt_q <= wr ? 2'h0 : (qt_q != 2'h3) ? qt_q + 2'h1 : qt_q;
    end
  end
  // --------------------------------
  // properties
  // --------------------------------
  sequence s_ack;
    ack_o ##1 !ack_o;
  endsequence
  property p_ack;
    cyc_i && stb_i && !ack_o |=> s_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_rd;
    ack_o && !we_i |-> dat_o[31:16] == 16'h0 && (adr_i <= 8'h48 || dat_o == 32'h0);
  endproperty
  a_rd: assert property (p_rd) else $error("read data not zero");
  property p_comp;
    en_q && !ctl_q[2] && qt_q == 2'h3 |-> pwm_low_out[0] == !h0;
  endproperty
  a_comp: assert property (p_comp) else $error("low pin not inverse");
  property p_indep;
    en_q && ctl_q[2] && qt_q == 2'h3 |-> pwm_low_out[0] == h0;
  endproperty
  a_indep: assert property (p_indep) else $error("low pin not copy");
  property p_off;
    !en_q && qt_q == 2'h3 |-> pwm_high_out == 4'h0 && pwm_low_out == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("pins active while off");
  property p_fine;
    en_q && ctl_q[0] && !ctl_q[3] && qt_q == 2'h3 |-> fine_adjust[2:0] == dut_q[2:0];
  endproperty
  a_fine: assert property (p_fine) else $error("fine code wrong");
  property p_per;
    $rose(h0) && run |-> gap_q == {1'b0, per_q[15:3]} + 14'h1;
  endproperty
  a_per: assert property (p_per) else $error("period wrong");
  property p_wid;
    $fell(h0) && run && ph_q == 16'h0 |-> hi_q == {1'b0, dut_q[15:3]} + 14'h1;
  endproperty
  a_wid: assert property (p_wid) else $error("on time wrong");
endmodule
bind pwmc_core pwmc_core_props pwmc_core_props_i (.clk_sys, .rstn, .cyc_i, .stb_i, .we_i,
  .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .pwm_high_out, .pwm_low_out, .fine_adjust);
`default_nettype wire

// *** bench/pwmc_fet_model.sv ***
// gate driver and power stage on pair 0: times the high pin
// assumes the pin changes just after rising edges of clk_sys
`timescale 1ns/1ps
`default_nettype none
module pwmc_fet_model (
  // clock
  input wire logic clk_sys,
  // gate drive
  input wire logic hi,
  // last on-time and period, in clock cycles
  output logic [13:0] on_len = 14'h0,
  output logic [13:0] per_len = 14'h0
);
  logic [13:0] on_c = 14'h0;
  logic [13:0] pc = 14'h0;
  logic hl = 1'b0;
  // a real stage cannot resolve the fine edge code, only whole cycles
  always @(posedge clk_sys) begin
    hl <= hi;
    on_c <= hi ? on_c + 14'h1 : 14'h0;
    pc <= (hi && !hl) ? 14'h1 : pc + 14'h1;
    if (!hi && hl) begin
      on_len <= on_c;
    end
    if (hi && !hl) begin
      per_len <= pc;
    end
  end
endmodule
`default_nettype wire

// *** bench/test_pwm_period_phase_duty_core.sv ***
// bench: register and pin checks for pwmc_core
// assumes 100 mhz clk_sys and the fet model on pair 0
`timescale 1ns/1ps
`default_nettype none
module test_pwm_period_phase_duty_core;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rdat;
  logic ack_o;
  logic [3:0] hi, lo;
  logic [11:0] fine;
  logic [13:0] on_len, per_len;
  int n_errors = 0;
  int samples_checked = 0;
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  pwmc_core pwmc_core_i (.clk_sys, .rstn, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .pwm_high_out(hi), .pwm_low_out(lo), .fine_adjust(fine));
  pwmc_fet_model pwmc_fet_model_i (.clk_sys, .hi(hi[0]), .on_len, .per_len);
  // --------------------------------
  // tasks
  // --------------------------------
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    do begin
      @(posedge clk_sys);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    if (ack_o !== 1'b1) begin
      n_errors++;
      $display("BAD t=%0t no ack", $time);
      end_sim();
    end
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // --------------------------------
  // sequence
  // --------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rd(8'h04, 32'hfff8);
    rd(8'h00, 32'h0);
    rd(8'hfc, 32'h0);
    chk({24'h0, hi, lo}, 32'h0);
    bus(1'b1, 8'h08, 32'hffff1234);
    rd(8'h08, 32'h1234);
    for (int g = 1; g < 5; g++) begin
      bus(1'b1, 8'(16 * g + 4), 32'hffff5a5d);
      rd(8'(16 * g + 4), 32'h5a5d);
      bus(1'b1, 8'(16 * g + 8), 32'hffef);
      rd(8'(16 * g + 8), 32'hffef);
    end
    bus(1'b1, 8'h04, 32'h28);
    bus(1'b1, 8'h14, 32'h0);
    bus(1'b1, 8'h18, 32'h1b);
    bus(1'b1, 8'h10, 32'h1);
    bus(1'b1, 8'h00, 32'h1);
    repeat (60) @(posedge clk_sys);
    chk({18'h0, per_len}, 32'h6);
    chk({18'h0, on_len}, 32'h4);
    chk({29'h0, fine[2:0]}, 32'h3);
    chk({31'h0, lo[0]}, {31'h0, ~hi[0]});
    chk({29'h0, hi[3:1]}, 32'h7);
    chk({29'h0, lo[3:1]}, 32'h0);
    chk({23'h0, fine[11:3]}, 32'h1ff);
    bus(1'b1, 8'h04, 32'h40);
    repeat (60) @(posedge clk_sys);
    chk({18'h0, per_len}, 32'h9);
    bus(1'b1, 8'h08, 32'h10);
    bus(1'b1, 8'h10, 32'h9);
    repeat (60) @(posedge clk_sys);
    chk({18'h0, on_len}, 32'h3);
    // stop first: a counter already past a lower phase would run round all 13 bits
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h10, 32'h3);
    bus(1'b1, 8'h14, 32'h20);
    bus(1'b1, 8'h00, 32'h1);
    repeat (60) @(posedge clk_sys);
    chk({18'h0, per_len}, 32'h5);
    bus(1'b1, 8'h10, 32'h5);
    repeat (12) begin
      @(posedge clk_sys);
      chk({31'h0, lo[0]}, {31'h0, hi[0]});
    end
    bus(1'b1, 8'h10, 32'h1);
    bus(1'b1, 8'h18, 32'h7);
    repeat (40) @(posedge clk_sys);
    repeat (20) begin
      @(posedge clk_sys);
      chk({31'h0, hi[0]}, 32'h0);
    end
    bus(1'b1, 8'h00, 32'h0);
    repeat (3) @(posedge clk_sys);
    chk({24'h0, hi, lo}, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
